// ===== common/odcd_pkg.sv
/*
 * Constants and types for the octal converter command decoder.
 * Assumes a 16-bit command word sent most significant bit first.
 */
package odcd_pkg;

  localparam int NCH = 8;
  localparam int DW = 12;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;

  localparam logic [3:0] CMD_REG_MODE = 4'h8;
  localparam logic [3:0] CMD_IMM_MODE = 4'h9;
  localparam logic [3:0] CMD_UPD_SEL = 4'ha;
  localparam logic [3:0] CMD_CHA_WRITE = 4'hb;
  localparam logic [3:0] CMD_BCAST = 4'hc;
  localparam logic [3:0] CMD_PD_HIZ = 4'hd;
  localparam logic [3:0] CMD_PD_100K = 4'he;
  localparam logic [3:0] CMD_PD_2K5 = 4'hf;

  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_HIZ = 2'h1;
  localparam logic [1:0] TERM_100K = 2'h2;
  localparam logic [1:0] TERM_2K5 = 2'h3;

  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [7:0] CH_NONE = 8'h00;
  localparam logic [7:0] CH_A = 8'h01;
  localparam logic [7:0] CH_ALL = 8'hff;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic {MODE_REG, MODE_IMM} odcd_mode_t;

  typedef struct packed {
    logic [3:0] command_nibble;
    logic [11:0] payload_bits;
  } odcd_word_t;

  typedef logic [7:0][11:0] odcd_codes_t;
  typedef logic [7:0][1:0] odcd_terms_t;

  typedef struct packed {
    logic [7:0] load;
    logic [7:0] update;
    logic [11:0] value;
  } odcd_bank_req_t;

endpackage

// ===== verilog/odcd_chan_bank.sv
/*
 * Eight channel data registers and eight output code registers.
 * Assumes requests are one-cycle strobes already gated by the clock enable.
 */
module odcd_chan_bank (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input odcd_pkg::odcd_bank_req_t req_i,
  output odcd_pkg::odcd_codes_t data_o,
  output odcd_pkg::odcd_codes_t code_o
);

  odcd_pkg::odcd_codes_t data_q;
  odcd_pkg::odcd_codes_t data_d;
  odcd_pkg::odcd_codes_t code_q;
  odcd_pkg::odcd_codes_t code_d;

  // An output that loads and updates in one frame takes the new value.
  for (genvar i = 0; i < odcd_pkg::NCH; i++) begin : g_ch
    assign data_d[i] = req_i.load[i] ? req_i.value : data_q[i];
    assign code_d[i] = !req_i.update[i] ? code_q[i] :
                       (req_i.load[i] ? req_i.value : data_q[i]);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= {odcd_pkg::NCH{odcd_pkg::CODE_RST}};
      code_q <= {odcd_pkg::NCH{odcd_pkg::CODE_RST}};
    end else begin
      data_q <= data_d;
      code_q <= code_d;
    end
  end

  assign data_o = data_q;
  assign code_o = code_q;

endmodule

// ===== verilog/odcd_top.sv
/*
 * Command decoder for an eight-channel 12-bit converter: serial frame
 * capture on the link clock, decode and channel control on the core clock.
 * Assumes the host stops the link clock while frame sync is high.
 */
//
// Contract
// - Broadcast loads all registers and outputs.
// - Update-select refreshes chosen outputs from registers.
// - Channel A write also refreshes others.
// - Reset clears registers, outputs stay zero.
// - Three power-down commands pick termination.
// - Power-down channels selected by low byte.
// - Bias stops only when all down.
// - Power-down keeps data registers intact.
// - Register-load mode writes register only.
// - Channel write: index bits, twelve-bit code.
// - Word a00f updates channels A-D.
// - Nibble nine selects immediate-update mode.
// - Immediate mode writes register and output.
// - Word bfff sets A in any mode.
// - Nibble eight selects register-load mode.
// - Bits fourteen to twelve select channel.
// - Frame spans sync low, executes on rise.
// - Sample data on clock fall, MSB first.
module odcd_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic link_sclk_i,
  input wire logic link_sync_n_i,
  input wire logic link_din_i,
  output odcd_pkg::odcd_codes_t dac_code_o,
  output logic [7:0] chan_pd_o,
  output odcd_pkg::odcd_terms_t chan_term_o,
  output logic bias_en_o,
  output logic imm_mode_o,
  output logic cmd_exec_o,
  output logic frame_drop_o
);

  function automatic logic [7:0] chan_onehot(input logic [2:0] idx);
    chan_onehot = odcd_pkg::CH_A << idx;
  endfunction

  function automatic logic [1:0] term_of(input logic [3:0] cmd);
    case (cmd)
      odcd_pkg::CMD_PD_HIZ: term_of = odcd_pkg::TERM_HIZ;
      odcd_pkg::CMD_PD_100K: term_of = odcd_pkg::TERM_100K;
      odcd_pkg::CMD_PD_2K5: term_of = odcd_pkg::TERM_2K5;
      default: term_of = odcd_pkg::TERM_NONE;
    endcase
  endfunction

  // Link domain: shift register and bit counter on the serial clock.

  logic [15:0] shift_q;
  logic [4:0] bits_q;
  logic new_frame_q;
  wire logic frame_idle_w = link_sync_n_i | sys_rst_i;

  // The first falling edge after sync falls restarts the count.
  always_ff @(negedge link_sclk_i or posedge frame_idle_w) begin
    if (frame_idle_w) begin
      new_frame_q <= 1'b1;
    end else begin
      new_frame_q <= 1'b0;
    end
  end

  always_ff @(negedge link_sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_q <= odcd_pkg::WORD_RST;
    end else if (!link_sync_n_i) begin
      shift_q <= {shift_q[14:0], link_din_i};
    end
  end

  wire logic [4:0] bits_inc_w = (bits_q == odcd_pkg::FRAME_BITS) ? bits_q :
                                5'(bits_q + odcd_pkg::CNT_ONE);

  always_ff @(negedge link_sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bits_q <= odcd_pkg::CNT_ZERO;
    end else if (!link_sync_n_i) begin
      bits_q <= new_frame_q ? odcd_pkg::CNT_ONE : bits_inc_w;
    end
  end

  // Core domain: frame sync passes two flip-flops, a third finds the rise.
  // Shift word and count are static once sync is high and the clock stops.

  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_s3_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
      sync_s3_q <= 1'b1;
    end else if (ce_i) begin
      sync_s1_q <= link_sync_n_i;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  wire logic rise_w = ce_i && sync_s2_q && !sync_s3_q;
  wire logic full_w = (bits_q == odcd_pkg::FRAME_BITS);
  wire logic exec_w = rise_w && full_w;
  wire logic drop_w = rise_w && !full_w;

  odcd_pkg::odcd_word_t word_w;
  assign word_w = shift_q;
  wire logic [3:0] cmd_w = word_w.command_nibble;
  wire logic [11:0] pay_w = word_w.payload_bits;

  logic [7:0] pd_q;
  odcd_pkg::odcd_terms_t term_q;
  odcd_pkg::odcd_mode_t mode_q;
  logic started_q;
  logic bias_q;
  logic imm_q;
  logic exec_q;
  logic drop_q;

  // Decode of the command nibble into register loads and output updates.
  wire logic is_write_w = !cmd_w[3];
  wire logic [7:0] wr_ch_w = chan_onehot(cmd_w[2:0]);
  wire logic is_pd_w = (term_of(cmd_w) != odcd_pkg::TERM_NONE);
  wire logic imm_w = (mode_q == odcd_pkg::MODE_IMM);

  wire logic [7:0] load_w =
    is_write_w ? wr_ch_w :
    (cmd_w == odcd_pkg::CMD_CHA_WRITE) ? odcd_pkg::CH_A :
    (cmd_w == odcd_pkg::CMD_BCAST) ? odcd_pkg::CH_ALL :
    odcd_pkg::CH_NONE;

  wire logic [7:0] upd_w =
    is_write_w ? (imm_w ? wr_ch_w : odcd_pkg::CH_NONE) :
    (cmd_w == odcd_pkg::CMD_UPD_SEL) ? pay_w[7:0] :
    (cmd_w == odcd_pkg::CMD_CHA_WRITE) ? odcd_pkg::CH_ALL :
    (cmd_w == odcd_pkg::CMD_BCAST) ? odcd_pkg::CH_ALL :
    odcd_pkg::CH_NONE;

  // Power-down only touches the status of the selected channels.
  wire logic [7:0] pd_set_w = is_pd_w ? pay_w[7:0] : odcd_pkg::CH_NONE;

  odcd_pkg::odcd_bank_req_t req_w;
  assign req_w.load = exec_w ? load_w : odcd_pkg::CH_NONE;
  assign req_w.update = exec_w ? upd_w : odcd_pkg::CH_NONE;
  assign req_w.value = pay_w;

  wire logic [7:0] pd_d = exec_w ? ((pd_q | pd_set_w) & ~upd_w) : pd_q;

  odcd_pkg::odcd_terms_t term_d;
  for (genvar i = 0; i < odcd_pkg::NCH; i++) begin : g_term
    assign term_d[i] = !pd_d[i] ? odcd_pkg::TERM_NONE :
                       (exec_w && pd_set_w[i]) ? term_of(cmd_w) : term_q[i];
  end

  odcd_pkg::odcd_mode_t mode_d;
  always_comb begin
    mode_d = mode_q;
    if (exec_w) begin
      case (cmd_w)
        odcd_pkg::CMD_REG_MODE: mode_d = odcd_pkg::MODE_REG;
        odcd_pkg::CMD_IMM_MODE: mode_d = odcd_pkg::MODE_IMM;
        default: mode_d = mode_q;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pd_q <= odcd_pkg::CH_NONE;
      term_q <= {odcd_pkg::NCH{odcd_pkg::TERM_NONE}};
      mode_q <= odcd_pkg::MODE_REG;
      started_q <= 1'b0;
      bias_q <= 1'b1;
      imm_q <= 1'b0;
      exec_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (ce_i) begin
      pd_q <= pd_d;
      term_q <= term_d;
      mode_q <= mode_d;
      started_q <= started_q | exec_w;
      bias_q <= (pd_d != odcd_pkg::CH_ALL);
      imm_q <= (mode_d == odcd_pkg::MODE_IMM);
      exec_q <= exec_w;
      drop_q <= drop_w;
    end
  end

  odcd_pkg::odcd_codes_t data_w;

  // Registers reset to zero, so outputs hold zero code until a command.
  odcd_chan_bank u_bank (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req_w),
    .data_o(data_w),
    .code_o(dac_code_o)
  );

  assign chan_pd_o = pd_q;
  assign chan_term_o = term_q;
  assign bias_en_o = bias_q;
  assign imm_mode_o = imm_q;
  assign cmd_exec_o = exec_q;
  assign frame_drop_o = drop_q;

  // Checks on the core clock.

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  function automatic logic all_equal(input odcd_pkg::odcd_codes_t c,
                                     input logic [11:0] v);
    all_equal = 1'b1;
    for (int i = 0; i < odcd_pkg::NCH; i++) begin
      if (c[i] != v) begin
        all_equal = 1'b0;
      end
    end
  endfunction

  function automatic logic masked_same(input odcd_pkg::odcd_codes_t a,
                                       input odcd_pkg::odcd_codes_t b,
                                       input logic [7:0] keep);
    masked_same = 1'b1;
    for (int i = 0; i < odcd_pkg::NCH; i++) begin
      if (keep[i] && (a[i] != b[i])) begin
        masked_same = 1'b0;
      end
    end
  endfunction

  sequence s_cmd(logic [3:0] c);
    exec_w && (cmd_w == c);
  endsequence

  sequence s_write_in(odcd_pkg::odcd_mode_t m);
    exec_w && is_write_w && (mode_q == m);
  endsequence

  chk_bcast_all: assert property (
    s_cmd(odcd_pkg::CMD_BCAST) |=> all_equal(dac_code_o, $past(pay_w))
      && all_equal(data_w, $past(pay_w)))
    else $error("broadcast did not reach every channel");

  chk_upd_select: assert property (
    s_cmd(odcd_pkg::CMD_UPD_SEL) |=>
      masked_same(dac_code_o, $past(data_w), $past(pay_w[7:0]))
      && masked_same(dac_code_o, $past(dac_code_o), ~$past(pay_w[7:0])))
    else $error("update select touched the wrong channels");

  chk_cha_write: assert property (
    s_cmd(odcd_pkg::CMD_CHA_WRITE) |=> (dac_code_o[0] == $past(pay_w))
      && masked_same(dac_code_o, $past(data_w), 8'hfe)
      && (imm_mode_o == $past(imm_mode_o)))
    else $error("channel A write result wrong");

  chk_zero_start: assert property (
    !started_q |-> all_equal(dac_code_o, odcd_pkg::CODE_RST))
    else $error("output left zero before first command");

  chk_pd_select: assert property (
    exec_w && is_pd_w |=> ((chan_pd_o & $past(pay_w[7:0])) == $past(pay_w[7:0]))
      && (chan_term_o[0] == ($past(pay_w[0]) ? term_of($past(cmd_w))
                                             : $past(chan_term_o[0]))))
    else $error("power-down selection or termination wrong");

  chk_bias_off: assert property (
    (chan_pd_o == odcd_pkg::CH_ALL) == !bias_en_o)
    else $error("bias state disagrees with power-down state");

  chk_pd_keeps: assert property (
    exec_w && is_pd_w |=> (data_w == $past(data_w))
      && (dac_code_o == $past(dac_code_o)))
    else $error("power-down changed a register");

  chk_reg_load: assert property (
    s_write_in(odcd_pkg::MODE_REG) |=> $stable(dac_code_o)
      && (data_w[$past(cmd_w[2:0])] == $past(pay_w)))
    else $error("register-load write changed an output");

  chk_imm_write: assert property (
    s_write_in(odcd_pkg::MODE_IMM) |=>
      (dac_code_o[$past(cmd_w[2:0])] == $past(pay_w))
      && masked_same(dac_code_o, $past(dac_code_o), ~$past(wr_ch_w)))
    else $error("immediate write did not update its channel only");

  chk_mode_set: assert property (
    s_cmd(odcd_pkg::CMD_IMM_MODE) |=> imm_mode_o ##1 !rise_w [*2] ##0 imm_mode_o)
    else $error("immediate mode not held");

  chk_mode_back: assert property (
    s_cmd(odcd_pkg::CMD_REG_MODE) |=> !imm_mode_o)
    else $error("register-load mode not restored");

  chk_short_drop: assert property (
    drop_w |=> frame_drop_o && !cmd_exec_o && $stable(dac_code_o)
      && $stable(chan_pd_o))
    else $error("short frame was executed");

  chk_wake_up: assert property (
    exec_w && (upd_w != odcd_pkg::CH_NONE) |=> ((chan_pd_o & $past(upd_w)) == 8'h00))
    else $error("updated channel stayed powered down");

  chk_exec_rise: assert property (
    $rose(sync_s2_q) && ce_i && full_w |=> cmd_exec_o ##1 !cmd_exec_o)
    else $error("frame end did not execute exactly once");

endmodule

// ===== testbench/odcd_host_model.sv
/*
 * Host serial controller model that sends command frames.
 * Assumes a 64 ns link clock that runs only inside frames.
 */
module odcd_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end

  // Sends the low nbits of w, most significant first.
  task automatic send(input logic [31:0] w, input int nbits);
    #5;
    sync_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      din_o = w[i];
      #32;
      sclk_o = 1'b0;
      #32;
      sclk_o = 1'b1;
    end
    din_o = 1'b0;
    #32;
    sync_n_o = 1'b1;
  endtask
endmodule

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for the converter command decoder.
 * Assumes the host model drives the link and the core clock runs at 250 MHz.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i;
  logic sys_rst_i;
  logic ce_i;
  logic sclk;
  logic sync_n;
  logic din;
  odcd_pkg::odcd_codes_t dac_code;
  odcd_pkg::odcd_terms_t term;
  odcd_pkg::odcd_terms_t exp_t;
  odcd_pkg::odcd_codes_t exp_c;
  logic [7:0] chan_pd;
  logic bias_en;
  logic imm_mode;
  logic cmd_exec;
  logic frame_drop;
  logic got_exec;
  logic got_drop;
  int n_mismatch = 0;
  int checks_done = 0;

  odcd_host_model host (
    .sclk_o(sclk),
    .sync_n_o(sync_n),
    .din_o(din)
  );

  odcd_top dut (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .link_sclk_i(sclk),
    .link_sync_n_i(sync_n),
    .link_din_i(din),
    .dac_code_o(dac_code),
    .chan_pd_o(chan_pd),
    .chan_term_o(term),
    .bias_en_o(bias_en),
    .imm_mode_o(imm_mode),
    .cmd_exec_o(cmd_exec),
    .frame_drop_o(frame_drop)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_done();
    got_exec = 1'b0;
    got_drop = 1'b0;
    for (int i = 0; i < 40 && !(got_exec || got_drop); i++) begin
      @(posedge core_clk_i);
      #1;
      got_exec = (cmd_exec === 1'b1);
      got_drop = (frame_drop === 1'b1);
    end
    @(negedge core_clk_i);
  endtask

  task automatic frame(input logic [31:0] w, input int n = 16);
    host.send(w, n);
    wait_done();
  endtask

  task automatic t_reset();
    chk(dac_code, '0);
    chk(96'(chan_pd), 96'h0);
    chk(96'(bias_en), 96'h1);
    chk(96'(imm_mode), 96'h0);
  endtask

  task automatic t_reg_load();
    frame(32'h0fff);
    frame(32'h1c00);
    frame(32'h2800);
    frame(32'h3400);
    chk(dac_code, exp_c);
    frame(32'ha00f);
    exp_c[0] = 12'hfff;
    exp_c[1] = 12'hc00;
    exp_c[2] = 12'h800;
    exp_c[3] = 12'h400;
    chk(96'(got_exec), 96'h1);
    chk(dac_code, exp_c);
  endtask

  task automatic t_imm();
    frame(32'h9abc);
    chk(96'(imm_mode), 96'h1);
    frame(32'h6800);
    frame(32'h5fff);
    exp_c[6] = 12'h800;
    exp_c[5] = 12'hfff;
    chk(dac_code, exp_c);
    frame(32'h8000);
    chk(96'(imm_mode), 96'h0);
    frame(32'h7123);
    frame(32'h4777);
    chk(dac_code, exp_c);
    frame(32'ha080);
    exp_c[7] = 12'h123;
    chk(dac_code, exp_c);
  endtask

  task automatic t_cha();
    frame(32'hbfff);
    exp_c[4] = 12'h777;
    chk(dac_code, exp_c);
    chk(96'(imm_mode), 96'h0);
    frame(32'h9000);
    frame(32'hb5a5);
    exp_c[0] = 12'h5a5;
    chk(dac_code, exp_c);
    chk(96'(imm_mode), 96'h1);
    frame(32'h8000);
  endtask

  task automatic t_bcast();
    frame(32'hc321);
    for (int i = 0; i < 8; i++) begin
      exp_c[i] = 12'h321;
    end
    chk(dac_code, exp_c);
  endtask

  task automatic t_pd();
    exp_t = '0;
    frame(32'hdf03);
    exp_t[0] = odcd_pkg::TERM_HIZ;
    exp_t[1] = odcd_pkg::TERM_HIZ;
    chk(96'(chan_pd), 96'h03);
    chk(96'(term), 96'(exp_t));
    frame(32'he00c);
    exp_t[2] = odcd_pkg::TERM_100K;
    exp_t[3] = odcd_pkg::TERM_100K;
    chk(96'(term), 96'(exp_t));
    chk(96'(bias_en), 96'h1);
    frame(32'hf0ff);
    for (int i = 0; i < 8; i++) begin
      exp_t[i] = odcd_pkg::TERM_2K5;
    end
    chk(96'(term), 96'(exp_t));
    chk(96'(bias_en), 96'h0);
    frame(32'ha0ff);
    chk(96'({chan_pd, term, bias_en}), 96'h1);
    chk(dac_code, exp_c);
  endtask

  task automatic t_frames();
    frame(32'h90, 8);
    chk(96'({got_drop, imm_mode}), 96'h2);
    frame(32'h39000, 20);
    chk(96'(imm_mode), 96'h1);
    // Clock enable drops after the sync fall is captured, so the rise waits for it.
    fork
      host.send(32'h8000, 16);
      begin
        @(negedge sync_n);
        repeat (4) @(negedge core_clk_i);
        ce_i = 1'b0;
        @(posedge sync_n);
        repeat (8) @(negedge core_clk_i);
      end
    join
    chk(96'({cmd_exec, imm_mode}), 96'h1);
    ce_i = 1'b1;
    wait_done();
    chk(96'(got_exec), 96'h1);
    chk(96'(imm_mode), 96'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    exp_c = '0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    t_reset();
    t_reg_load();
    t_imm();
    t_cha();
    t_bcast();
    t_pd();
    t_frames();
    finish_test();
  end
endmodule
